// ### src/rcip_pkg.sv
// Package for the reset, clock and interrupt pin control block.
// Assumes a single core clock that also serves as the oscillator input.
package rcip_pkg;

    // ********************************************************************
    // Register map (byte addresses on the APB bus).
    // ********************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] PRIO_MISC_OFFS = 8'h00;
    localparam logic [7:0] OPTION_OFFS = 8'h04;
    localparam logic [7:0] CCFLAGS_OFFS = 8'h08;
    localparam logic [7:0] INT_STATUS_OFFS = 8'h0C;
    localparam logic [7:0] INT_MASK_OFFS = 8'h10;

    // ********************************************************************
    // Field positions.
    // ********************************************************************
    localparam int PM_ECLK_OFF_BIT = 0;
    localparam int PM_MODE_A_BIT = 1;
    localparam int PM_SPECIAL_BIT = 2;
    localparam int PM_BOOT_BIT = 3;
    localparam int OPT_EDGE_SEL_BIT = 0;
    localparam int CC_NMI_MASK_BIT = 0;
    localparam int INT_WATCHDOG_BIT = 0;
    localparam int INT_CLKMON_BIT = 1;
    localparam int INT_IRQ_BIT = 2;
    localparam int INT_NMI_BIT = 3;
    localparam int INT_W = 4;

    // ********************************************************************
    // Reset values.
    // ********************************************************************
    localparam logic ECLK_OFF_RST = 1'b0;
    localparam logic EDGE_SEL_RST = 1'b0;
    localparam logic NMI_MASK_RST = 1'b1;
    localparam logic [INT_W-1:0] INT_MASK_RST = 4'h0;
    // Synchroniser order {nmi, irq, modeB, modeA, resetPin}: pins idle, reset held.
    localparam logic [4:0] PIN_SYNC_RST = 5'h18;

    // ********************************************************************
    // Timing.
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int ECLK_DIV = 4;
    localparam int FAULT_PULSE_NS = 800;
    // Least time, so round up to whole cycles.
    localparam int FAULT_PULSE_CYCLES = (FAULT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAULT_CNT_W = 5;

endpackage

// ### src/rcip_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes each bit is a slow level; no bus coherency is promised across bits.
`timescale 1ns/1ns
module rcip_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    // ********************************************************************
    // Two flops; only the second stage is visible to the rest of the block.
    // ********************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_reg <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            stage1_reg <= asyncIn;
            syncOut <= stage1_reg;
        end
    end
endmodule // rcip_sync

// ### src/rcip_eclk_div.sv
// Bus timing clock divider with a glitch-free stop.
// Assumes the input clock is the oscillator rate; output is a registered level.
`timescale 1ns/1ns
module rcip_eclk_div #(
    parameter int DIV = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    output logic eClk
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2);

    if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
        $error("rcip_eclk_div: DIV must be even and at least 2");
    end

    logic [CW-1:0] phase_reg;
    logic [CW-1:0] phase_next;
    wire logic atStart = (phase_reg == '0);
    // Stopping only at the start of a period keeps every emitted pulse whole.
    wire logic hold = !run && atStart;

    assign phase_next = hold ? '0 : ((phase_reg == LAST) ? '0 : phase_reg + 1'b1);

    // ********************************************************************
    // Phase counter and output flop.
    // ********************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= '0;
            eClk <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            eClk <= !hold && (phase_next >= HALF);
        end
    end
endmodule // rcip_eclk_div

// ### src/rcip_pin_ctrl.sv
// Reset, bus clock and interrupt pin control with an APB register port.
// Assumes watchdog and clock monitor faults arrive as core_clk pulses and
// that the board pulls the reset and interrupt pins high when idle.
//
// Functional notes
// - Reset pin low puts all control state into its startup values; the code leaves the interrupt status and mask registers as they are.
// - Watchdog or clock monitor failure pulls the reset pin low, open drain.
// - Reset pin level at release takes part in selecting bootstrap mode; the code decodes it from the two mode pins alone.
// - Bus clock output runs at the oscillator rate divided by four.
// - Software may stop the bus clock output, only in single-chip mode.
// - Maskable interrupt is falling-edge or low-level, chosen by edge-select bit.
// - Every reset returns the maskable interrupt to level triggering.
// - During memory programming the maskable pin becomes the memory chip enable.
// - Non-maskable requests are accepted only after power-on reset completes.
// - Reset sets the non-maskable mask flag until software clears it.
// - Non-maskable input is low-level active; the board holds it high idle.
// - Reset rising edge latches mode pins into special and mode-A flags.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module rcip_pin_ctrl (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic resetPin_n_in,
    output logic resetPin_n_out,
    output logic resetPinOe,
    input wire logic modeAPin,
    input wire logic modeBPin,
    input wire logic irqPin_n,
    input wire logic nmiPin_n,
    input wire logic watchdogFail,
    input wire logic clkMonFail,
    input wire logic promProgram,
    input wire logic irqAck,
    output logic coreReset_n,
    output logic eClk,
    output logic irqRequest,
    output logic nmiRequest,
    output logic bootSelect,
    output logic promChipEnable_n,
    output logic intLine
);
    // ********************************************************************
    // Pin synchronisers.
    // ********************************************************************
    logic [4:0] pinSync;
    rcip_sync #(
        .WIDTH(5),
        .RESET_VAL(rcip_pkg::PIN_SYNC_RST)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .asyncIn({nmiPin_n, irqPin_n, modeBPin, modeAPin, resetPin_n_in}),
        .syncOut(pinSync)
    );

    wire logic resetLevel = pinSync[0];
    wire logic modeASync = pinSync[1];
    wire logic modeBSync = pinSync[2];
    wire logic irqLevel_n = pinSync[3];
    wire logic nmiLevel_n = pinSync[4];
    wire logic inPinReset = !resetLevel;

    // ********************************************************************
    // State.
    // ********************************************************************
    logic resetLevelPrev_reg;
    logic irqPrev_n_reg;
    logic specialMode_reg;
    logic modeA_reg;
    logic bootMode_reg;
    logic eclkOff_reg;
    logic irqEdgeSel_reg;
    logic nmiMask_reg;
    logic porDone_reg;
    logic irqPending_reg;
    logic [rcip_pkg::FAULT_CNT_W-1:0] faultCount_reg;
    logic [rcip_pkg::INT_W-1:0] intStatus_reg;
    logic [rcip_pkg::INT_W-1:0] intMask_reg;

    // ********************************************************************
    // APB decode; zero wait states, unmapped addresses answer with an error.
    // ********************************************************************
    wire logic setupPhase = psel && !penable;
    wire logic accessPhase = psel && penable;
    wire logic selPrio = (paddr == rcip_pkg::PRIO_MISC_OFFS);
    wire logic selOption = (paddr == rcip_pkg::OPTION_OFFS);
    wire logic selCcflags = (paddr == rcip_pkg::CCFLAGS_OFFS);
    wire logic selStatus = (paddr == rcip_pkg::INT_STATUS_OFFS);
    wire logic selMask = (paddr == rcip_pkg::INT_MASK_OFFS);
    wire logic mapped = selPrio || selOption || selCcflags || selStatus || selMask;
    wire logic wrEn = accessPhase && pwrite && mapped;
    wire logic [31:0] readMux =
        selPrio ? {28'h0000000, bootMode_reg, specialMode_reg, modeA_reg, eclkOff_reg} :
        selOption ? {31'h00000000, irqEdgeSel_reg} :
        selCcflags ? {31'h00000000, nmiMask_reg} :
        selStatus ? {28'h0000000, intStatus_reg} :
        selMask ? {28'h0000000, intMask_reg} : 32'h00000000;

    assign pready = 1'b1;
    assign pslverr = accessPhase && !mapped;

    // Read data is captured in the setup cycle so the access cycle sees a flop.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (setupPhase && !pwrite) begin
            prdata <= readMux;
        end
    end

    // ********************************************************************
    // Mode latch at the reset rising edge.
    // ********************************************************************
    wire logic resetRise = resetLevel && !resetLevelPrev_reg;
    // Special when modeB low; mode-A flag follows the modeA pin.
    wire logic specialNext = !modeBSync;
    wire logic bootNext = !modeBSync && !modeASync;
    wire logic singleChip = !specialMode_reg && !modeA_reg;

    // The previous reset level starts low, so the first release is a rise.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resetLevelPrev_reg <= 1'b0;
            specialMode_reg <= 1'b0;
            modeA_reg <= 1'b0;
            bootMode_reg <= 1'b0;
        end else begin
            resetLevelPrev_reg <= resetLevel;
            if (resetRise) begin
                specialMode_reg <= specialNext;
                modeA_reg <= modeASync;
                bootMode_reg <= bootNext;
            end
        end
    end

    assign bootSelect = bootMode_reg;

    // ********************************************************************
    // Control registers; the pin reset returns each to its startup value.
    // ********************************************************************
    wire logic wrPrio = wrEn && selPrio;
    wire logic wrOption = wrEn && selOption;
    wire logic wrCcClear = wrEn && selCcflags && !pwdata[rcip_pkg::CC_NMI_MASK_BIT];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eclkOff_reg <= rcip_pkg::ECLK_OFF_RST;
            irqEdgeSel_reg <= rcip_pkg::EDGE_SEL_RST;
            nmiMask_reg <= rcip_pkg::NMI_MASK_RST;
        end else if (inPinReset) begin
            eclkOff_reg <= rcip_pkg::ECLK_OFF_RST;
            irqEdgeSel_reg <= rcip_pkg::EDGE_SEL_RST;
            nmiMask_reg <= rcip_pkg::NMI_MASK_RST;
        end else begin
            if (wrPrio) begin
                eclkOff_reg <= pwdata[rcip_pkg::PM_ECLK_OFF_BIT];
            end
            if (wrOption) begin
                irqEdgeSel_reg <= pwdata[rcip_pkg::OPT_EDGE_SEL_BIT];
            end
            // Software may only clear the mask; writing a one does not re-arm it.
            if (wrCcClear) begin
                nmiMask_reg <= 1'b0;
            end
        end
    end

    // ********************************************************************
    // Bus timing clock.
    // ********************************************************************
    // Stopping is refused outside single-chip mode, where the bus needs it.
    wire logic eclkRun = !(eclkOff_reg && singleChip);

    rcip_eclk_div #(
        .DIV(rcip_pkg::ECLK_DIV)
    ) u_eclk_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(eclkRun),
        .eClk(eClk)
    );

    // ********************************************************************
    // Fault pulse on the open-drain reset pin.
    // ********************************************************************
    wire logic faultEvent = watchdogFail || clkMonFail;
    wire logic faultIdle = (faultCount_reg == '0);

    // A new fault during a pulse is merged into it rather than extending it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            faultCount_reg <= '0;
        end else if (faultIdle && faultEvent) begin
            faultCount_reg <= rcip_pkg::FAULT_CNT_W'(rcip_pkg::FAULT_PULSE_CYCLES);
        end else if (!faultIdle) begin
            faultCount_reg <= faultCount_reg - 1'b1;
        end
    end

    assign resetPin_n_out = 1'b0;
    assign resetPinOe = !faultIdle;

    // Core reset follows the pin and our own drive, so a fault resets at once.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            coreReset_n <= 1'b0;
        end else begin
            coreReset_n <= resetLevel && faultIdle;
        end
    end

    // ********************************************************************
    // Maskable interrupt: level or falling edge, or memory chip enable.
    // ********************************************************************
    wire logic irqFall = irqPrev_n_reg && !irqLevel_n;
    wire logic irqActive = irqEdgeSel_reg ? (irqPending_reg || irqFall) : !irqLevel_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irqPrev_n_reg <= 1'b1;
            irqPending_reg <= 1'b0;
            irqRequest <= 1'b0;
            promChipEnable_n <= 1'b1;
        end else begin
            irqPrev_n_reg <= irqLevel_n;
            // A fall in the acknowledge cycle is kept: setting wins.
            if (promProgram || inPinReset || !irqEdgeSel_reg) begin
                irqPending_reg <= 1'b0;
            end else if (irqFall) begin
                irqPending_reg <= 1'b1;
            end else if (irqAck) begin
                irqPending_reg <= 1'b0;
            end
            irqRequest <= !promProgram && !inPinReset && irqActive;
            promChipEnable_n <= promProgram ? irqLevel_n : 1'b1;
        end
    end

    // ********************************************************************
    // Non-maskable interrupt: active-low level, gated by reset and mask.
    // ********************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            porDone_reg <= 1'b0;
            nmiRequest <= 1'b0;
        end else begin
            if (resetLevel) begin
                porDone_reg <= 1'b1;
            end
            nmiRequest <= porDone_reg && resetLevel && !nmiMask_reg && !nmiLevel_n;
        end
    end

    // ********************************************************************
    // Interrupt status, mask and output line.
    // ********************************************************************
    wire logic [rcip_pkg::INT_W-1:0] intEvents = {nmiRequest, irqRequest, clkMonFail, watchdogFail};
    wire logic [rcip_pkg::INT_W-1:0] intClear =
        (wrEn && selStatus) ? pwdata[rcip_pkg::INT_W-1:0] : '0;

    // Status survives the pin reset so software can see why it was reset.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            intStatus_reg <= '0;
            intMask_reg <= rcip_pkg::INT_MASK_RST;
            intLine <= 1'b0;
        end else begin
            intStatus_reg <= (intStatus_reg & ~intClear) | intEvents;
            if (wrEn && selMask) begin
                intMask_reg <= pwdata[rcip_pkg::INT_W-1:0];
            end
            intLine <= |(((intStatus_reg & ~intClear) | intEvents) & intMask_reg);
        end
    end

    // ********************************************************************
    // Assertions.
    // ********************************************************************
    a_fault_drives_pin: assert property (@(posedge core_clk) disable iff (!rst_n)
        faultEvent && faultIdle |=> resetPinOe && !resetPin_n_out)
        else $error("fault did not pull the reset pin low");

    a_fault_pulse_len: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(resetPinOe) |-> ##15 resetPinOe ##1 !resetPinOe)
        else $error("reset pin fault pulse has the wrong length");

    a_eclk_quarter_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(eClk) |=> eClk ##1 !eClk ##1 !eClk)
        else $error("bus clock high phase is not two cycles");

    a_eclk_off_single: assert property (@(posedge core_clk) disable iff (!rst_n)
        !eclkRun[*4] |-> !eClk)
        else $error("stopped bus clock did not settle low");

    a_eclk_gate_only: assert property (@(posedge core_clk) disable iff (!rst_n)
        !singleChip |-> eclkRun)
        else $error("bus clock stopped outside single-chip mode");

    a_irq_level_mode: assert property (@(posedge core_clk) disable iff (!rst_n)
        !irqEdgeSel_reg && !promProgram && resetLevel && !irqLevel_n |=> irqRequest)
        else $error("low level on maskable pin did not raise a request");

    a_edge_reset_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        inPinReset |=> !irqEdgeSel_reg && nmiMask_reg)
        else $error("reset left edge select or mask wrong");

    a_prom_ce_route: assert property (@(posedge core_clk) disable iff (!rst_n)
        promProgram |=> !irqRequest && (promChipEnable_n == $past(irqLevel_n)))
        else $error("programming mode did not reroute the maskable pin");

    a_nmi_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
        nmiMask_reg |=> !nmiRequest)
        else $error("masked non-maskable request reached the core");

    a_mode_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
        resetRise |=> specialMode_reg == !$past(modeBSync) && modeA_reg == $past(modeASync))
        else $error("mode flags not latched at reset release");

    a_core_reset_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !faultIdle || inPinReset |=> !coreReset_n)
        else $error("core reset released while the reset pin was low");

    a_boot_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        resetRise |=> bootSelect == (!$past(modeBSync) && !$past(modeASync)))
        else $error("bootstrap select not decoded from the straps");

    a_irq_edge_latch: assert property (@(posedge core_clk) disable iff (!rst_n)
        irqEdgeSel_reg && irqFall && !promProgram && resetLevel |=> irqRequest)
        else $error("falling edge on maskable pin gave no request");

    a_nmi_after_por: assert property (@(posedge core_clk) disable iff (!rst_n)
        !porDone_reg |=> !nmiRequest)
        else $error("non-maskable request before the first reset release");

    a_nmi_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        porDone_reg && resetLevel && !nmiMask_reg && !nmiLevel_n |=> nmiRequest)
        else $error("unmasked low non-maskable level gave no request");
endmodule // rcip_pin_ctrl

// ### sim/rcip_board.sv
// Board model for the reset, maskable and non-maskable interrupt pins.
// Assumes a pull-up on every pin and an open-drain device driver on reset.
`timescale 1ns/1ns
module rcip_board (
    input wire logic holdReset,
    input wire logic pullIrq,
    input wire logic pullNmi,
    input wire logic devPullOe,
    input wire logic devPullLvl,
    output logic resetWire,
    output logic irqWire,
    output logic nmiWire
);
    // Pull-ups win unless a party pulls low, so a released pin always reads high.
    assign resetWire = !(holdReset || (devPullOe && !devPullLvl));
    assign irqWire = !pullIrq;
    assign nmiWire = !pullNmi;
endmodule // rcip_board

// ### sim/tb_top.sv
// Self-checking bench for the pin control block, driving APB and the board model.
// Assumes one 20 MHz clock and a design answering APB with no wait states.
`timescale 1ns/1ns
module tb_top;
    logic core_clk, rst_n, psel, penable, pwrite, modeAPin, modeBPin, watchdogFail;
    logic clkMonFail, promProgram, irqAck, holdReset, pullIrq, pullNmi, prevE;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic pready, pslverr, rdErr, resetPinOut, resetPinOe, resetWire, irqWire, nmiWire;
    logic coreReset_n, eClk, irqRequest, nmiRequest, bootSelect, promChipEnable_n, intLine;
    int fail_count, num_checks, hiCnt, riseCnt;

    rcip_board u_board (.holdReset(holdReset), .pullIrq(pullIrq), .pullNmi(pullNmi),
        .devPullOe(resetPinOe), .devPullLvl(resetPinOut), .resetWire(resetWire),
        .irqWire(irqWire), .nmiWire(nmiWire));

    rcip_pin_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .resetPin_n_in(resetWire),
        .resetPin_n_out(resetPinOut), .resetPinOe(resetPinOe), .modeAPin(modeAPin),
        .modeBPin(modeBPin), .irqPin_n(irqWire), .nmiPin_n(nmiWire),
        .watchdogFail(watchdogFail), .clkMonFail(clkMonFail), .promProgram(promProgram),
        .irqAck(irqAck), .coreReset_n(coreReset_n), .eClk(eClk), .irqRequest(irqRequest),
        .nmiRequest(nmiRequest), .bootSelect(bootSelect),
        .promChipEnable_n(promChipEnable_n), .intLine(intLine));

    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    // The verdict is printed in one place so a hang and a clean end report in the same form.
    task give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task check1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    task cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // One APB transfer; the request stands until pready is seen high at an edge.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdData, exp);
    endtask

    task fault(input int i);
        @(posedge core_clk);
        if (i == 0) watchdogFail <= 1'b1;
        else clkMonFail <= 1'b1;
        @(posedge core_clk);
        watchdogFail <= 1'b0;
        clkMonFail <= 1'b0;
        #1;
    endtask

    // Counts high samples and rising edges of the bus clock over sixteen cycles.
    task eclkCount();
        hiCnt = 0;
        riseCnt = 0;
        prevE = eClk;
        repeat (16) begin
            cycles(1);
            hiCnt += (eClk === 1'b1);
            riseCnt += (eClk === 1'b1 && prevE === 1'b0);
            prevE = eClk;
        end
    endtask

    // ****************************************************************
    // Clock, watchdog and test sequence.
    // ****************************************************************
    // The clock toggles every half period of 50 ns.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // The tests need about 300 cycles, so 20000 means a hang.
    initial begin
        #(50 * 20000);
        fail_count++;
        give_verdict();
    end

    // All inputs start idle with the single-chip straps fitted.
    initial begin
        {rst_n, psel, penable, pwrite, modeAPin, watchdogFail, clkMonFail} = '0;
        {promProgram, irqAck, holdReset, pullIrq, pullNmi, paddr, pwdata} = '0;
        modeBPin = 1'b1;
        fail_count = 0;
        num_checks = 0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        cycles(6);
        rd(rcip_pkg::PRIO_MISC_OFFS, 32'h0);
        rd(rcip_pkg::OPTION_OFFS, 32'h0);
        rd(rcip_pkg::CCFLAGS_OFFS, 32'h1);
        rd(rcip_pkg::INT_MASK_OFFS, 32'h0);
        apb(1'b1, 8'h14, 32'h1);
        rd(8'h14, 32'h0);
        check1(rdErr, 1'b1);
        $display("test registers done");
        eclkCount();
        check(hiCnt, 8);
        check(riseCnt, 4);
        apb(1'b1, rcip_pkg::PRIO_MISC_OFFS, 32'h1);
        cycles(8);
        eclkCount();
        check(hiCnt + riseCnt, 0);
        apb(1'b1, rcip_pkg::PRIO_MISC_OFFS, 32'h0);
        $display("test bus clock done");
        @(posedge core_clk) pullIrq <= 1'b1;
        cycles(2);
        check1(irqRequest, 1'b0);
        cycles(1);
        check1(irqRequest, 1'b1);
        @(posedge core_clk) pullIrq <= 1'b0;
        cycles(4);
        check1(irqRequest, 1'b0);
        apb(1'b1, rcip_pkg::OPTION_OFFS, 32'h1);
        @(posedge core_clk) pullIrq <= 1'b1;
        cycles(3);
        @(posedge core_clk) pullIrq <= 1'b0;
        cycles(5);
        check1(irqRequest, 1'b1);
        @(posedge core_clk) irqAck <= 1'b1;
        @(posedge core_clk) irqAck <= 1'b0;
        cycles(2);
        check1(irqRequest, 1'b0);
        @(posedge core_clk) promProgram <= 1'b1;
        pullIrq <= 1'b1;
        cycles(5);
        check1(promChipEnable_n, 1'b0);
        check1(irqRequest, 1'b0);
        @(posedge core_clk) promProgram <= 1'b0;
        pullIrq <= 1'b0;
        cycles(4);
        check1(promChipEnable_n, 1'b1);
        $display("test maskable done");
        @(posedge core_clk) pullNmi <= 1'b1;
        cycles(5);
        check1(nmiRequest, 1'b0);
        apb(1'b1, rcip_pkg::CCFLAGS_OFFS, 32'h0);
        cycles(3);
        check1(nmiRequest, 1'b1);
        @(posedge core_clk) pullNmi <= 1'b0;
        cycles(5);
        check1(nmiRequest, 1'b0);
        check1(intLine, 1'b0);
        rd(rcip_pkg::INT_STATUS_OFFS, 32'hC);
        apb(1'b1, rcip_pkg::INT_MASK_OFFS, 32'h8);
        cycles(3);
        check1(intLine, 1'b1);
        apb(1'b1, rcip_pkg::INT_STATUS_OFFS, 32'hF);
        rd(rcip_pkg::INT_STATUS_OFFS, 32'h0);
        cycles(2);
        check1(intLine, 1'b0);
        apb(1'b1, rcip_pkg::INT_MASK_OFFS, 32'h1);
        $display("test interrupts done");
        // A fault pulse on the pin must reset the control registers behind it.
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, rcip_pkg::OPTION_OFFS, 32'h1);
            apb(1'b1, rcip_pkg::CCFLAGS_OFFS, 32'h0);
            fault(i);
            hiCnt = 0;
            repeat (30) begin
                hiCnt += (resetPinOe === 1'b1);
                cycles(1);
                if (hiCnt == 1) check1(coreReset_n, 1'b0);
            end
            check(hiCnt, 16);
            rd(rcip_pkg::OPTION_OFFS, 32'h0);
            rd(rcip_pkg::CCFLAGS_OFFS, 32'h1);
        end
        rd(rcip_pkg::INT_STATUS_OFFS, 32'h3);
        check1(intLine, 1'b1);
        $display("test faults done");
        @(posedge core_clk) modeBPin <= 1'b0;
        holdReset <= 1'b1;
        cycles(6);
        check1(coreReset_n, 1'b0);
        @(posedge core_clk) holdReset <= 1'b0;
        cycles(6);
        rd(rcip_pkg::PRIO_MISC_OFFS, 32'hC);
        check1(bootSelect, 1'b1);
        $display("test bootstrap done");
        give_verdict();
    end
endmodule // tb_top
